// ---- verilog/spd_pkg.sv ----
/*
  Constants for the short-window power detector and transmit gate.
  Assumes register indices are word indices on APB (byte addr = 4 * index).
*/
package spd_pkg;
  localparam int NCONV = 2;
  localparam int POWER_W = 13;
  localparam int SAMPLE_W = 16;
  localparam int MSB_USED = 6;
  localparam int MASK_W = 9;
  // register indices
  localparam logic [11:0] IDX_PAGE = 12'h008;
  localparam logic [11:0] IDX_SP_CTRL = 12'h58A;
  localparam logic [11:0] IDX_SP_LOW = 12'h58B;
  localparam logic [11:0] IDX_SP_HIGH = 12'h58C;
  localparam logic [11:0] IDX_FSM_CTRL = 12'h58D;
  localparam logic [11:0] IDX_OVR = 12'h596;
  localparam logic [11:0] IDX_MASK_LOW = 12'h597;
  localparam logic [11:0] IDX_MASK_HIGH = 12'h598;
  localparam logic [11:0] IDX_FLUSH = 12'h599;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h5A0;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h5A1;
  // field positions
  localparam int SP_ON_BIT = 7;
  localparam int OVR_VALUE_BIT = 3;
  localparam int OVR_ON_BIT = 2;
  localparam int FSM_ON_BIT = 0;
  localparam int FLUSH_BIT = 0;
  // reset values
  localparam logic [1:0] PAGE_RST = 2'h1;
  localparam logic [7:0] FSM_CTRL_RST = 8'h02;
  localparam logic FLUSH_RST = 1'b1;
  // power-averaging clock multipliers, in dac periods
  localparam logic [7:0] PA_MULT_BOTH = 8'h04;
  localparam logic [7:0] PA_MULT_CHAN1 = 8'h08;
  localparam logic [7:0] PA_FIXED = 8'h20;
  typedef enum logic [2:0] {
    GATE_OFF = 3'b001,
    GATE_ON = 3'b010,
    GATE_TRIP = 3'b100
  } gate_state_e;
endpackage

// ---- verilog/power_slice.sv ----
/*
  One converter's power averager, threshold check and transmit gate.
  Assumes pa_tick is a one-cycle strobe per power-averaging clock period.
*/
`timescale 1ns/1ps
module power_slice (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pa_tick,
  input wire logic [spd_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic [spd_pkg::SAMPLE_W-1:0] sample_q,
  input wire logic power_on,
  input wire logic [1:0] window_exp,
  input wire logic [spd_pkg::POWER_W-1:0] power_limit,
  input wire logic fsm_on,
  input wire logic override_on,
  input wire logic override_value,
  input wire logic gate_pin,
  output logic [spd_pkg::POWER_W-1:0] avg_power,
  output logic power_error,
  output logic error_event,
  output logic tx_gate_en
);
  import spd_pkg::*;

  logic signed [MSB_USED-1:0] i_top;
  logic signed [MSB_USED-1:0] q_top;
  logic signed [2*MSB_USED-1:0] i_sq;
  logic signed [2*MSB_USED-1:0] q_sq;
  logic [POWER_W-1:0] inst_power;
  logic [15:0] acc_reg;
  logic [15:0] acc_sum;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_last;
  logic gate_req;
  gate_state_e state_reg;
  gate_state_e state_next;

  // only the top bits of each sample feed the squarer
  assign i_top = sample_i[SAMPLE_W-1 -: MSB_USED];
  assign q_top = sample_q[SAMPLE_W-1 -: MSB_USED];
  assign i_sq = i_top * i_top;
  assign q_sq = q_top * q_top;
  assign inst_power = {1'b0, i_sq} + {1'b0, q_sq};
  assign acc_sum = acc_reg + {3'h0, inst_power};
  assign cnt_last = 4'((1 << window_exp) - 1); // window = 2^exp ticks

  // averager; sum of 2^exp samples shifted back down is the mean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 16'h0000;
      cnt_reg <= 4'h0;
      avg_power <= 13'h0000;
      power_error <= 1'b0;
    end else if (!power_on) begin // both calculation and check idle
      acc_reg <= 16'h0000;
      cnt_reg <= 4'h0;
      power_error <= 1'b0;
    end else if (pa_tick) begin
      if (cnt_reg >= cnt_last) begin
        acc_reg <= 16'h0000;
        cnt_reg <= 4'h0;
        avg_power <= POWER_W'(acc_sum >> window_exp);
        power_error <= POWER_W'(acc_sum >> window_exp) > power_limit;
      end else begin
        acc_reg <= acc_sum;
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end

  // one-cycle pulse on each rising error, feeds the sticky status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_event <= 1'b0;
    end else begin
      error_event <= power_on && pa_tick && cnt_reg >= cnt_last &&
                     POWER_W'(acc_sum >> window_exp) > power_limit && !power_error;
    end
  end

  // software value replaces the pin when override is on
  assign gate_req = override_on ? override_value : gate_pin;

  // gate fsm: a trip holds enable low until the request drops
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      GATE_OFF: begin
        if (fsm_on && gate_req && !power_error) begin
          state_next = GATE_ON;
        end
      end
      GATE_ON: begin
        if (!fsm_on || !gate_req) begin
          state_next = GATE_OFF;
        end else if (power_error) begin
          state_next = GATE_TRIP;
        end
      end
      GATE_TRIP: begin
        if (!fsm_on || !gate_req) begin
          state_next = GATE_OFF;
        end
      end
      default: state_next = GATE_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= GATE_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // without the fsm the request passes straight through
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_gate_en <= 1'b0;
    end else if (fsm_on) begin
      tx_gate_en <= state_next == GATE_ON;
    end else begin
      tx_gate_en <= gate_req;
    end
  end
endmodule // power_slice

// ---- verilog/short_power_detect_tx_gate.sv ----
/*
  Short-window power detector and transmit gate for two converters, APB slave.
  Assumes sample and pin inputs are synchronous to pclk, one dac period per pclk.
*/
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module short_power_detect_tx_gate (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] main_interp,
  input wire logic [3:0] chan_interp,
  input wire logic [spd_pkg::NCONV-1:0][spd_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic [spd_pkg::NCONV-1:0][spd_pkg::SAMPLE_W-1:0] sample_q,
  input wire logic [spd_pkg::NCONV-1:0] tx_gate_pin,
  output logic [spd_pkg::NCONV-1:0] tx_gate_en,
  output logic [spd_pkg::NCONV-1:0] short_power_error,
  output logic [spd_pkg::NCONV-1:0] datapath_flush_on,
  output logic [spd_pkg::NCONV-1:0][spd_pkg::MASK_W-1:0] link_protect_irq_mask,
  output logic irq
);
  import spd_pkg::*;

  logic [1:0] converter_page_select;
  logic [NCONV-1:0] short_avg_power_on;
  logic [NCONV-1:0][1:0] short_avg_window_exp;
  logic [NCONV-1:0][POWER_W-1:0] short_avg_power_limit;
  logic [NCONV-1:0][POWER_W-1:0] short_avg_power_value;
  logic [NCONV-1:0][7:0] fsm_ctrl_reg;
  logic [NCONV-1:0] sw_tx_gate_value;
  logic [NCONV-1:0] sw_tx_gate_override_on;
  logic [NCONV-1:0][MASK_W-1:0] mask_reg;
  logic [NCONV-1:0] flush_reg;
  logic [NCONV-1:0] error_event;
  logic [NCONV-1:0] irq_status_reg;
  logic [NCONV-1:0] irq_mask_reg;
  logic [7:0] pa_period;
  logic [7:0] pa_cnt_reg;
  logic pa_tick;
  logic [11:0] idx;
  logic wr_en;
  logic rd_sel;
  logic mapped;
  logic [31:0] rdata_next;

  // power-averaging period in dac periods (= pclk cycles)
  always_comb begin
    if (main_interp > 4'h1 && chan_interp > 4'h1) begin
      pa_period = 8'(PA_MULT_BOTH * main_interp);
    end else if (chan_interp == 4'h1 && main_interp > 4'h1) begin
      pa_period = 8'(PA_MULT_CHAN1 * main_interp);
    end else begin
      pa_period = PA_FIXED;
    end
  end

  // free-running divider; one tick per averaging period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_cnt_reg <= 8'h00;
    end else if (pa_cnt_reg >= pa_period - 8'h01) begin
      pa_cnt_reg <= 8'h00;
    end else begin
      pa_cnt_reg <= pa_cnt_reg + 8'h01;
    end
  end
  assign pa_tick = pa_cnt_reg >= pa_period - 8'h01;

  // apb decode; printed offsets are word indices
  assign idx = paddr[13:2];
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_sel = !converter_page_select[0]; // reads come from lowest paged

  // page select; a write may page both converters at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_page_select <= PAGE_RST;
    end else if (wr_en && idx == IDX_PAGE) begin
      converter_page_select <= pwdata[1:0];
    end
  end

  // paged power controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_avg_power_on <= '0;
      short_avg_window_exp <= '0;
      short_avg_power_limit <= '0;
    end else begin
      for (int c = 0; c < NCONV; c++) begin
        if (wr_en && converter_page_select[c]) begin
          if (idx == IDX_SP_CTRL) begin
            short_avg_power_on[c] <= pwdata[SP_ON_BIT];
            short_avg_window_exp[c] <= pwdata[1:0];
          end
          if (idx == IDX_SP_LOW - 12'h003) begin
            short_avg_power_limit[c][7:0] <= pwdata[7:0];
          end
          if (idx == IDX_SP_LOW - 12'h002) begin
            short_avg_power_limit[c][12:8] <= pwdata[4:0];
          end
        end
      end
    end
  end

  // paged gate controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCONV; c++) begin
        fsm_ctrl_reg[c] <= FSM_CTRL_RST; // fsm bit clear
      end
      sw_tx_gate_value <= '0;
      sw_tx_gate_override_on <= '0;
    end else begin
      for (int c = 0; c < NCONV; c++) begin
        if (wr_en && converter_page_select[c]) begin
          if (idx == IDX_FSM_CTRL) begin
            fsm_ctrl_reg[c] <= pwdata[7:0];
          end
          if (idx == IDX_OVR) begin
            sw_tx_gate_value[c] <= pwdata[OVR_VALUE_BIT];
            sw_tx_gate_override_on[c] <= pwdata[OVR_ON_BIT];
          end
        end
      end
    end
  end

  // paged link mask and flush enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= '0;
      flush_reg <= {NCONV{FLUSH_RST}}; // flush on by default
    end else begin
      for (int c = 0; c < NCONV; c++) begin
        if (wr_en && converter_page_select[c]) begin
          if (idx == IDX_MASK_LOW) begin
            mask_reg[c][7:0] <= pwdata[7:0];
          end
          if (idx == IDX_MASK_HIGH) begin
            mask_reg[c][8] <= pwdata[0];
          end
          if (idx == IDX_FLUSH) begin
            flush_reg[c] <= pwdata[FLUSH_BIT];
          end
        end
      end
    end
  end

  // sticky error status, write one to clear; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      if (wr_en && idx == IDX_IRQ_MASK) begin
        irq_mask_reg <= pwdata[NCONV-1:0];
      end
      if (wr_en && idx == IDX_IRQ_STATUS) begin
        irq_status_reg <= (irq_status_reg & ~pwdata[NCONV-1:0]) | error_event;
      end else begin
        irq_status_reg <= irq_status_reg | error_event;
      end
    end
  end

  // irq registered so the output comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // read mux; reserved bits read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    mapped = 1'b1;
    case (idx)
      IDX_PAGE: rdata_next[1:0] = converter_page_select;
      IDX_SP_LOW - 12'h003: rdata_next[7:0] = short_avg_power_limit[rd_sel][7:0];
      IDX_SP_LOW - 12'h002: rdata_next[4:0] = short_avg_power_limit[rd_sel][12:8];
      IDX_SP_CTRL: begin
        rdata_next[SP_ON_BIT] = short_avg_power_on[rd_sel];
        rdata_next[1:0] = short_avg_window_exp[rd_sel];
      end
      IDX_SP_LOW: rdata_next[7:0] = short_avg_power_value[rd_sel][7:0];
      IDX_SP_HIGH: rdata_next[4:0] = short_avg_power_value[rd_sel][12:8];
      IDX_FSM_CTRL: rdata_next[7:0] = fsm_ctrl_reg[rd_sel];
      IDX_OVR: begin
        rdata_next[OVR_VALUE_BIT] = sw_tx_gate_value[rd_sel];
        rdata_next[OVR_ON_BIT] = sw_tx_gate_override_on[rd_sel];
      end
      IDX_MASK_LOW: rdata_next[7:0] = mask_reg[rd_sel][7:0];
      IDX_MASK_HIGH: rdata_next[0] = mask_reg[rd_sel][8];
      IDX_FLUSH: rdata_next[FLUSH_BIT] = flush_reg[rd_sel];
      IDX_IRQ_STATUS: rdata_next[NCONV-1:0] = irq_status_reg;
      IDX_IRQ_MASK: rdata_next[NCONV-1:0] = irq_mask_reg;
      default: mapped = 1'b0;
    endcase
  end

  // one wait-free access: data and ready valid through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rdata_next : 32'h0000_0000;
    end
  end

  // outputs registered one cycle after the control flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      datapath_flush_on <= {NCONV{FLUSH_RST}};
      link_protect_irq_mask <= '0;
    end else begin
      datapath_flush_on <= flush_reg;
      link_protect_irq_mask <= mask_reg;
    end
  end

  // one power and gate slice per converter
  for (genvar c = 0; c < NCONV; c++) begin : g_slice
    power_slice u_slice (
      .pclk(pclk),
      .presetn(presetn),
      .pa_tick(pa_tick),
      .sample_i(sample_i[c]),
      .sample_q(sample_q[c]),
      .power_on(short_avg_power_on[c]),
      .window_exp(short_avg_window_exp[c]),
      .power_limit(short_avg_power_limit[c]),
      .fsm_on(fsm_ctrl_reg[c][FSM_ON_BIT]),
      .override_on(sw_tx_gate_override_on[c]),
      .override_value(sw_tx_gate_value[c]),
      .gate_pin(tx_gate_pin[c]),
      .avg_power(short_avg_power_value[c]),
      .power_error(short_power_error[c]),
      .error_event(error_event[c]),
      .tx_gate_en(tx_gate_en[c])
    );
  end
endmodule // short_power_detect_tx_gate

// ---- tb/spd_checker.sv ----
/*
  Port-level checker for the short power detector and transmit gate.
  Assumes the top module's ports only; bound at the foot of this file.
*/
`timescale 1ns/1ps
module spd_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [spd_pkg::NCONV-1:0] tx_gate_pin,
  input wire logic [spd_pkg::NCONV-1:0] tx_gate_en,
  input wire logic [spd_pkg::NCONV-1:0] short_power_error,
  input wire logic [spd_pkg::NCONV-1:0] datapath_flush_on,
  input wire logic [spd_pkg::NCONV-1:0][spd_pkg::MASK_W-1:0] link_protect_irq_mask
);
  import spd_pkg::*;
  logic quiet_reg;
  logic mapped;
  logic unmapped;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // no write yet: defaults still rule, so outputs are predictable from pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_reg <= 1'b1;
    else if (psel && pwrite) quiet_reg <= 1'b0;
  end
  // decoded word indices; misaligned addresses left out on purpose
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[15:2] inside {14'h008,
    [14'h588:14'h58D], [14'h596:14'h599], 14'h5A0, 14'h5A1});
  assign unmapped = (paddr[1:0] == 2'h0) && !mapped;
  sequence setup_s;
    psel && !penable;
  endsequence
  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property (pready |-> $past(psel && !penable))
    else $error("ready without a setup before");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error outside access");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_rdata_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_unmapped_refused: assert property (setup_s ##0 unmapped |=> pslverr)
    else $error("unmapped index not refused");
  a_mapped_accepted: assert property (setup_s ##0 mapped |=> !pslverr)
    else $error("mapped index refused");
  a_flush_reset_on: assert property ($rose(presetn) |-> datapath_flush_on == 2'b11)
    else $error("flush not on after reset");
  a_gate_follows_pin: assert property (quiet_reg |=> tx_gate_en == $past(tx_gate_pin))
    else $error("gate does not follow pin");
  a_quiet_no_error: assert property (quiet_reg |-> short_power_error == 2'b00)
    else $error("error while detector off");
  a_quiet_mask_clear: assert property (quiet_reg |-> link_protect_irq_mask == '0)
    else $error("mask not clear after reset");
endmodule // spd_checker

bind short_power_detect_tx_gate spd_checker spd_checker_inst (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .tx_gate_pin, .tx_gate_en,
  .short_power_error, .datapath_flush_on, .link_protect_irq_mask);

// ---- tb/tb.sv ----
/*
  Self-checking bench for the short power detector and transmit gate.
  Assumes one pclk per dac period; the bench is the APB master and the data source.
*/
`timescale 1ns/1ps
module tb;
  import spd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, pin0, pin1, exceed;
  logic [15:0] paddr, si, sq;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] main_interp, chan_interp;
  logic [NCONV-1:0][SAMPLE_W-1:0] sample_i, sample_q;
  logic [NCONV-1:0] tx_gate_pin, tx_gate_en, short_power_error, datapath_flush_on;
  logic [NCONV-1:0][MASK_W-1:0] link_protect_irq_mask;
  logic [12:0] inst, lim;
  int seed, num_errors, comparisons, n, per, e, k;
  logic [11:0] idx_t [8] = '{IDX_SP_CTRL, IDX_SP_LOW, IDX_SP_HIGH, IDX_FSM_CTRL, IDX_OVR,
    IDX_MASK_LOW, IDX_MASK_HIGH, IDX_FLUSH};
  logic [7:0] rst_t [8] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01};
  logic [7:0] ff_t [8] = '{8'h83, 8'h00, 8'h00, 8'hFF, 8'h0C, 8'hFF, 8'h01, 8'h01};
  int mains [4] = '{2, 3, 4, 1};
  int chans [4] = '{2, 4, 1, 1};
  assign tx_gate_pin = {pin1, pin0};
  short_power_detect_tx_gate short_power_detect_tx_gate_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_interp(main_interp), .chan_interp(chan_interp), .sample_i(sample_i),
    .sample_q(sample_q), .tx_gate_pin(tx_gate_pin), .tx_gate_en(tx_gate_en),
    .short_power_error(short_power_error), .datapath_flush_on(datapath_flush_on),
    .link_protect_irq_mask(link_protect_irq_mask), .irq(irq));
  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // converter 1 sees random traffic so paging mistakes show up
  always @(posedge pclk) begin
    pin1 <= 1'($random(seed));
    sample_i[1] <= 16'($random(seed));
  end
  // expected power, top six bits of each sample only
  function automatic logic [12:0] pwr(input logic [15:0] i, input logic [15:0] q);
    int a, b;
    a = $signed(i[15:10]);
    b = $signed(q[15:10]);
    return 13'(a * a + b * b);
  endfunction
  // averaging period in pclk cycles
  function automatic int pa_period(input int m, input int c);
    if (m > 1 && c > 1) return 4 * m;
    if (c == 1 && m > 1) return 8 * m;
    return 32;
  endfunction
  task automatic stop_test();
    $display("counts: %0d compares, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer; held until ready is sampled high
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] d);
    int w;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    // look at ready once it has settled, never in the edge that launches it
    #1;
    while (pready !== 1'b1 && w < 20) begin
      @(posedge pclk);
      #1;
      w++;
    end
    if (pready !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    // the edge that samples ready high completes the transfer
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    seed = 91;
    presetn = 1'b0;
    {psel, penable, pwrite, pin0, pin1} = 5'h00;
    paddr = 16'h0000;
    pwdata = 32'h0;
    main_interp = 4'h2;
    chan_interp = 4'h2;
    sample_i = '0;
    sample_q = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, IDX_PAGE, 0);
    chk(rd, 32'h1);
    for (k = 0; k < 8; k++) begin
      apb(0, idx_t[k], 0);
      chk(rd, 32'(rst_t[k]));
      apb(1, idx_t[k], 32'hFF);
      apb(0, idx_t[k], 0);
      chk(rd, 32'(ff_t[k]));
      apb(1, idx_t[k], 32'(rst_t[k]));
    end
    apb(1, 12'hFFF, 32'hFF);
    chk(32'(err), 1);
    apb(0, 12'hFFF, 0);
    chk({rd[30:0], err}, 1);
    $display("test registers done");
    apb(1, IDX_PAGE, 32'h2);
    apb(1, IDX_MASK_LOW, 32'hA5);
    apb(1, IDX_MASK_HIGH, 32'h1);
    apb(1, IDX_FLUSH, 32'h0);
    apb(0, IDX_MASK_LOW, 0);
    chk(rd, 32'hA5);
    chk(32'(link_protect_irq_mask), 32'h1A5 << 9);
    chk(32'(datapath_flush_on), 32'h1);
    apb(1, IDX_PAGE, 32'h1);
    $display("test paging done");
    apb(1, IDX_OVR, 32'h0C);
    repeat (3) @(posedge pclk);
    chk(32'(tx_gate_en[0]), 1);
    pin0 <= 1'b1;
    apb(1, IDX_OVR, 32'h04);
    repeat (3) @(posedge pclk);
    chk(32'(tx_gate_en[0]), 0);
    apb(1, IDX_OVR, 32'h00);
    repeat (3) @(posedge pclk);
    chk(32'(tx_gate_en[0]), 1);
    apb(1, IDX_OVR, 32'h0C);
    apb(1, IDX_FSM_CTRL, 32'h03);
    repeat (3) @(posedge pclk);
    chk(32'(tx_gate_en[0]), 1);
    $display("test gate done");
    for (int t = 0; t < 6; t++) begin
      apb(1, IDX_SP_CTRL, 0);
      e = $random(seed) & 3;
      n = $random(seed) & 3;
      per = pa_period(mains[n], chans[n]);
      si = 16'($random(seed));
      si[15] = ~si[14];
      sq = 16'($random(seed));
      inst = pwr(si, sq);
      exceed = (t == 5) ? 1'b1 : 1'($random(seed));
      lim = exceed ? inst - 13'h1 : inst;
      main_interp <= 4'(mains[n]);
      chan_interp <= 4'(chans[n]);
      sample_i[0] <= si;
      sample_q <= {16'($random(seed)), sq};
      apb(1, 12'h588, 32'(lim[7:0]));
      apb(1, 12'h589, 32'(lim[12:8]));
      apb(1, IDX_SP_CTRL, 32'h80 | e);
      n = 0;
      do begin
        @(posedge pclk);
        #1;
        n++;
      end while (short_power_error[0] !== 1'b1 && n < (per << e) + 8);
      chk(32'(short_power_error[0]), 32'(exceed));
      if (exceed) chk(32'(n > ((1 << e) - 1) * per && n <= (per << e) + 4), 1);
      apb(0, IDX_SP_LOW, 0);
      chk(rd, 32'(inst[7:0]));
      apb(0, IDX_SP_HIGH, 0);
      chk(rd, 32'(inst[12:8]));
    end
    chk(32'(tx_gate_en[0]), 0);
    apb(1, IDX_SP_CTRL, 0);
    repeat (3) @(posedge pclk);
    chk(32'(short_power_error[0]), 0);
    apb(1, IDX_OVR, 32'h04);
    apb(1, IDX_OVR, 32'h0C);
    repeat (3) @(posedge pclk);
    chk(32'(tx_gate_en[0]), 1);
    $display("test power done");
    apb(0, IDX_IRQ_STATUS, 0);
    chk({rd[30:0], irq}, 32'h2);
    apb(1, IDX_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 1);
    apb(1, IDX_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 0);
    apb(1, IDX_IRQ_MASK, 32'h1);
    apb(1, IDX_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    apb(0, IDX_IRQ_STATUS, 0);
    chk({rd[30:0], irq}, 0);
    $display("test interrupt done");
    stop_test();
  end
endmodule // tb
